// [src/lsgp_consts.svh]
// register offsets, field positions and reset values for the shared lcd gpio ports
`ifndef LSGP_CONSTS_SVH
`define LSGP_CONSTS_SVH
`define LSGP_OFF_PC_LATCH   12'h000
`define LSGP_OFF_PC_DIR     12'h004
`define LSGP_OFF_PE_LATCH   12'h008
`define LSGP_OFF_PE_DIR     12'h00C
`define LSGP_OFF_LCD_ONE    12'h010
`define LSGP_OFF_LCD_THREE  12'h014
`define LSGP_OFF_LCD_FOUR   12'h018
`define LSGP_OFF_LCD_FIVE   12'h01C
`define LSGP_OFF_LCD_SIX    12'h020
`define LSGP_OFF_STANDBY    12'h024
`define LSGP_OFF_RMW        12'h028
`define LSGP_OFF_STATUS     12'h02C
`define LSGP_DIR_RST        8'h00
`define LSGP_LATCH_RST      8'h00
`define LSGP_SEG_RST        8'h00
`define LSGP_LCD_PORT_INPUT_CONTROL_BIT      0
`define LSGP_FLOAT_BIT      0
`define LSGP_RMW_BIT        0
`endif

// [src/lsgp_pkg.sv]
// types shared by the shared lcd gpio ports block
package lsgp_pkg;
  typedef logic [7:0] lsgp_byte_t; // one port's worth of bits
  typedef enum logic [1:0] {
    LSGP_SRC_PORT,
    LSGP_SRC_LCD,
    LSGP_SRC_TIMER
  } lsgp_src_e;                   // which source drives a pin
endpackage

// [src/lsgp_ports.sv]
// two 8-bit gpio ports sharing pins with lcd segments and timer channel 1, apb slave
// How it works
// (RQ1) direction one drives pin from latch
// (RQ2) latch write shows at once on outputs
// (RQ3) output pin read returns latch
// (RQ4) direction zero leaves driver off
// (RQ5) input pin write updates latch only
// (RQ6) input read pin; rmw read latch
// (RQ7) software disables peripheral before gpio use
// (RQ8) software clears select then sets lcd_port_input_control
// (RQ9) software sets select, clears direction, lcd_port_input_control
// (RQ10) port c selects in regs three, four
// (RQ11) port e selects in regs five, six
// (RQ12) enabled timer output owns port e pin
// (RQ13) timer driven pin reads pin level
// (RQ14) peripheral input: reads return pin level
// (RQ15) pe5, pe6 timer outputs; pe7 clock
// (RQ16) register bit n controls pin n
// (RQ17) reset clears all direction bits
// (RQ18) standby float forces all pins hi-z
// (RQ19) floated pin inputs held low
// (RQ20) float off keeps pin states in standby
// (RQ21) mux: timer, then lcd, then latch
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`include "lsgp_consts.svh"
module lsgp_ports
  import lsgp_pkg::*;
(
  input  wire logic        core_clk_i,      // system clock
  input  wire logic        reset_i,         // synchronous reset, high
  input  wire logic        psel_i,          // apb select
  input  wire logic        penable_i,       // apb access phase
  input  wire logic        pwrite_i,        // apb direction
  input  wire logic [11:0] paddr_i,         // apb byte address
  input  wire logic [31:0] pwdata_i,        // apb write data
  output logic      [31:0] prdata_o,        // apb read data
  output logic             pready_o,        // apb ready
  output logic             pslverr_o,       // apb error on unmapped address
  input  wire logic        standby_i,       // stop or watch mode active
  input  wire logic [7:0]  pc_pin_i,        // port c pin levels
  output logic      [7:0]  pc_pin_o,        // port c pin drive value
  output logic      [7:0]  pc_pin_oe_o,     // port c pin driver enable
  input  wire logic [7:0]  pe_pin_i,        // port e pin levels
  output logic      [7:0]  pe_pin_o,        // port e pin drive value
  output logic      [7:0]  pe_pin_oe_o,     // port e pin driver enable
  input  wire logic [7:0]  pc_seg_i,        // lcd segment levels for port c pins
  input  wire logic [7:0]  pe_seg_i,        // lcd segment levels for port e pins
  input  wire logic        timer1_output_a_i,  // timer output to pe6
  input  wire logic        timer1_output_a_en_i, // its output enable
  input  wire logic        timer1_output_b_i,  // timer output to pe5
  input  wire logic        timer1_output_b_en_i, // its output enable
  output logic             timer1_external_clock_o // pe7 input to timer
);

  // ==========================================================================
  // registers
  // every register takes one aligned 32-bit word, only bits of the low byte are kept
  // and the rest read back as zero; the latches keep their value whatever
  // the direction, so a pin turned to output later shows the last write
  // the segment selects sit in the word at the same bit positions that
  // the segment numbers take inside their own enable register, so software
  // can carry a segment map over without shifting it
  lsgp_byte_t pc_latch_q;       // port_c_output_latch
  lsgp_byte_t pc_dir_q;         // port_c_direction
  lsgp_byte_t pe_latch_q;       // port_e_output_latch
  lsgp_byte_t pe_dir_q;         // port_e_direction
  logic       lcd_port_input_control_q;          // lcd_port_input_control
  logic [5:0] seg_three_q;      // segment_select 07:02
  logic [1:0] seg_four_q;       // segment_select 09:08
  logic [1:0] seg_five_q;       // segment_select 23:22
  logic [5:0] seg_six_q;        // segment_select 29:24
  logic       float_q;          // standby_pin_float
  logic       rmw_q;            // data reads are rmw reads while set

  // ==========================================================================
  // synchronisers for pins and standby
  logic [7:0] pc_meta_q;        // first stage, port c
  logic [7:0] pc_sync_q;        // second stage, port c
  logic [7:0] pe_meta_q;        // first stage, port e
  logic [7:0] pe_sync_q;        // second stage, port e
  logic       stb_meta_q;       // first stage, standby
  logic       stb_sync_q;       // second stage, standby

  // two flops before any logic reads a pin
  // pins and the standby request come from outside this clock, so only the
  // second stage is ever read; a pin change shows in a data read two edges
  // later, and standby takes two edges to float the pins
  // reset clears both stages so the first reads after reset see low pins
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_meta_q  <= 8'h00;
      pc_sync_q  <= 8'h00;
      pe_meta_q  <= 8'h00;
      pe_sync_q  <= 8'h00;
      stb_meta_q <= 1'b0;
      stb_sync_q <= 1'b0;
    end else begin
      pc_meta_q  <= pc_pin_i;
      pc_sync_q  <= pc_meta_q;
      pe_meta_q  <= pe_pin_i;
      pe_sync_q  <= pe_meta_q;
      stb_meta_q <= standby_i;
      stb_sync_q <= stb_meta_q;
    end
  end

  // ==========================================================================
  // apb decode
  // every transfer takes one wait state: the first access cycle registers
  // the read data, the second raises pready, so the master samples data
  // that already stands; a write lands at the edge where pready is high
  logic wr_en;                  // write taken this cycle
  logic rd_en;                  // read data captured this cycle
  logic mapped;                 // address hits a register
  logic acc_first;              // first cycle of an access phase
  logic ack_q;                  // ready for the current access
  assign acc_first = psel_i & penable_i & ~ack_q;
  assign wr_en     = psel_i & penable_i & pwrite_i & ack_q;  // lands with pready
  assign rd_en     = acc_first & ~pwrite_i;                  // data ready by the pready edge
  assign pready_o  = ack_q;                                  // one wait state

  // answer flop: high for one cycle after the first access cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc_first;       // falls again after the handshake edge
    end
  end

  // decode an offset to a hit
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `LSGP_OFF_PC_LATCH, `LSGP_OFF_PC_DIR, `LSGP_OFF_PE_LATCH, `LSGP_OFF_PE_DIR,
      `LSGP_OFF_LCD_ONE, `LSGP_OFF_LCD_THREE, `LSGP_OFF_LCD_FOUR, `LSGP_OFF_LCD_FIVE,
      `LSGP_OFF_LCD_SIX, `LSGP_OFF_STANDBY, `LSGP_OFF_RMW, `LSGP_OFF_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign mapped    = is_mapped(paddr_i);
  // error answer only stands together with ready
  assign pslverr_o = psel_i & penable_i & ack_q & ~mapped;

  // ==========================================================================
  // pin state after standby override
  // the float bit only acts while standby is seen; with it clear, standby
  // changes nothing and driven levels stay on the pins
  // while floated the internal inputs read low, so an open pin cannot
  // toggle the timer clock input or leak through the input buffer
  logic floating;               // pins forced hi-z
  logic [7:0] pc_in;            // port c internal input
  logic [7:0] pe_in;            // port e internal input
  assign floating = stb_sync_q & float_q;   // RQ18 RQ20
  assign pc_in = floating ? 8'h00 : pc_sync_q; // RQ19
  assign pe_in = floating ? 8'h00 : pe_sync_q; // RQ19

  // gather segment selects by pin
  logic [7:0] pc_seg_sel;       // port c pins in lcd use
  logic [7:0] pe_seg_sel;       // port e pins in lcd use
  assign pc_seg_sel = {seg_four_q, seg_three_q}; // RQ10
  assign pe_seg_sel = {seg_six_q, seg_five_q};   // RQ11

  // choose a source for a pin
  function automatic lsgp_src_e pick_src(input logic periph_en, input logic seg_sel, input logic lcd_port_input_control);
    if (periph_en) begin
      pick_src = LSGP_SRC_TIMER;
    end else if (seg_sel && lcd_port_input_control) begin
      pick_src = LSGP_SRC_LCD;
    end else begin
      pick_src = LSGP_SRC_PORT;
    end
  endfunction

  // ==========================================================================
  // pin output multiplexers
  // priority per pin: enabled timer output, then the segment driver when
  // selected with the input control set, then latch and direction
  // float overrides every source last, so nothing drives in standby float
  // a timer output left enabled steals the pin from software, a known hazard
  always_comb begin
    lsgp_src_e src;
    logic      tval;
    src  = LSGP_SRC_PORT;
    tval = 1'b0;
    pc_pin_o    = 8'h00;
    pc_pin_oe_o = 8'h00;
    pe_pin_o    = 8'h00;
    pe_pin_oe_o = 8'h00;
    for (int n = 0; n < 8; n++) begin
      // port c: lcd or latch, bit n to pin n
      src = pick_src(1'b0, pc_seg_sel[n], lcd_port_input_control_q); // RQ21 RQ16
      case (src)
        LSGP_SRC_LCD: begin
          pc_pin_o[n]    = pc_seg_i[n];
          pc_pin_oe_o[n] = 1'b1;
        end
        default: begin
          pc_pin_o[n]    = pc_latch_q[n];       // RQ1 RQ2
          pc_pin_oe_o[n] = pc_dir_q[n];         // RQ4 RQ5
        end
      endcase
      // port e: timer outputs on pins 5 and 6
      src  = LSGP_SRC_PORT;
      tval = 1'b0;
      if (n == 5) begin
        src  = pick_src(timer1_output_b_en_i, pe_seg_sel[n], lcd_port_input_control_q); // RQ15 RQ12
        tval = timer1_output_b_i;
      end else if (n == 6) begin
        src  = pick_src(timer1_output_a_en_i, pe_seg_sel[n], lcd_port_input_control_q); // RQ15 RQ12
        tval = timer1_output_a_i;
      end else begin
        src  = pick_src(1'b0, pe_seg_sel[n], lcd_port_input_control_q); // RQ21
      end
      case (src)
        LSGP_SRC_TIMER: begin
          pe_pin_o[n]    = tval;
          pe_pin_oe_o[n] = 1'b1;
        end
        LSGP_SRC_LCD: begin
          pe_pin_o[n]    = pe_seg_i[n];
          pe_pin_oe_o[n] = 1'b1;
        end
        default: begin
          pe_pin_o[n]    = pe_latch_q[n];       // RQ1 RQ2
          pe_pin_oe_o[n] = pe_dir_q[n];         // RQ4 RQ5
        end
      endcase
    end
    if (floating) begin
      pc_pin_oe_o = 8'h00;                      // RQ18
      pe_pin_oe_o = 8'h00;                      // RQ18
    end
  end

  // pe7 feeds the timer clock through the blocked input
  assign timer1_external_clock_o = pe_in[7];    // RQ15 RQ14

  // ==========================================================================
  // data read value: latch for outputs or rmw, pin level otherwise
  // a pin owned by the timer or the segment driver reads its own level,
  // not the latch, even when its direction bit is set
  // the rmw flag stands until software clears it, so every data read
  // in between returns the latch
  function automatic lsgp_byte_t port_read(input lsgp_byte_t latch, input lsgp_byte_t dir,
                                           input lsgp_byte_t pin, input lsgp_byte_t drv, input logic rmw);
    if (rmw) begin
      port_read = latch;                        // RQ6 RQ13
    end else begin
      port_read = (dir & ~drv & latch) | (~(dir & ~drv) & pin); // RQ3 RQ6 RQ13 RQ14
    end
  endfunction

  // pins owned by timer or lcd read back their level
  lsgp_byte_t pc_periph;        // port c pins taken by lcd
  lsgp_byte_t pe_periph;        // port e pins taken by lcd or timer
  assign pc_periph = lcd_port_input_control_q ? pc_seg_sel : 8'h00;
  assign pe_periph = (lcd_port_input_control_q ? pe_seg_sel : 8'h00) |
                     {1'b0, timer1_output_a_en_i, timer1_output_b_en_i, 5'b00000};

  // ==========================================================================
  // read data register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr_i)
        `LSGP_OFF_PC_LATCH:  prdata_o <= {24'h000000, port_read(pc_latch_q, pc_dir_q, pc_in, pc_periph, rmw_q)};
        `LSGP_OFF_PC_DIR:    prdata_o <= {24'h000000, pc_dir_q};
        `LSGP_OFF_PE_LATCH:  prdata_o <= {24'h000000, port_read(pe_latch_q, pe_dir_q, pe_in, pe_periph, rmw_q)};
        `LSGP_OFF_PE_DIR:    prdata_o <= {24'h000000, pe_dir_q};
        `LSGP_OFF_LCD_ONE:   prdata_o <= {31'h00000000, lcd_port_input_control_q};
        `LSGP_OFF_LCD_THREE: prdata_o <= {24'h000000, seg_three_q, 2'b00};
        `LSGP_OFF_LCD_FOUR:  prdata_o <= {30'h00000000, seg_four_q};
        `LSGP_OFF_LCD_FIVE:  prdata_o <= {24'h000000, seg_five_q, 6'h00};
        `LSGP_OFF_LCD_SIX:   prdata_o <= {26'h0000000, seg_six_q};
        `LSGP_OFF_STANDBY:   prdata_o <= {31'h00000000, float_q};
        `LSGP_OFF_RMW:       prdata_o <= {31'h00000000, rmw_q};
        `LSGP_OFF_STATUS:    prdata_o <= {31'h00000000, floating};
        default:             prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // port latches and directions
  // writes land at the ready edge only, so a refused or half transfer
  // leaves the latches alone; direction resets to all inputs
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_latch_q <= `LSGP_LATCH_RST;
      pe_latch_q <= `LSGP_LATCH_RST;
      pc_dir_q   <= `LSGP_DIR_RST;                // RQ17
      pe_dir_q   <= `LSGP_DIR_RST;                // RQ17
    end else if (wr_en) begin
      case (paddr_i)
        `LSGP_OFF_PC_LATCH: pc_latch_q <= pwdata_i[7:0]; // RQ2 RQ5
        `LSGP_OFF_PC_DIR:   pc_dir_q   <= pwdata_i[7:0];
        `LSGP_OFF_PE_LATCH: pe_latch_q <= pwdata_i[7:0]; // RQ2 RQ5
        `LSGP_OFF_PE_DIR:   pe_dir_q   <= pwdata_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // lcd enable registers
  // software sets the selects first and the input control last, so no
  // pin switches source while half configured
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lcd_port_input_control_q     <= 1'b0;
      seg_three_q <= 6'h00;
      seg_four_q  <= 2'h0;
      seg_five_q  <= 2'h0;
      seg_six_q   <= 6'h00;
    end else if (wr_en) begin
      case (paddr_i)
        `LSGP_OFF_LCD_ONE:   lcd_port_input_control_q     <= pwdata_i[`LSGP_LCD_PORT_INPUT_CONTROL_BIT];
        `LSGP_OFF_LCD_THREE: seg_three_q <= pwdata_i[7:2];  // RQ10
        `LSGP_OFF_LCD_FOUR:  seg_four_q  <= pwdata_i[1:0];  // RQ10
        `LSGP_OFF_LCD_FIVE:  seg_five_q  <= pwdata_i[7:6];  // RQ11
        `LSGP_OFF_LCD_SIX:   seg_six_q   <= pwdata_i[5:0];  // RQ11
        default: begin
        end
      endcase
    end
  end

  // standby float bit and rmw read flag
  // both are plain software bits with no hardware set or clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      float_q <= 1'b0;
      rmw_q   <= 1'b0;
    end else if (wr_en) begin
      if (paddr_i == `LSGP_OFF_STANDBY) begin
        float_q <= pwdata_i[`LSGP_FLOAT_BIT];
      end
      if (paddr_i == `LSGP_OFF_RMW) begin
        rmw_q <= pwdata_i[`LSGP_RMW_BIT];
      end
    end
  end

endmodule // lsgp_ports

// [testbench/lsgp_pin_model.sv]
// board side of one 8-bit port: resolves design drive against the far side
`timescale 1ns/100ps
module lsgp_pin_model (
  input  wire logic       core_clk_i,  // system clock
  input  wire logic [7:0] pin_o_i,     // design drive value
  input  wire logic [7:0] pin_oe_i,    // design drive enable
  input  wire logic [7:0] ext_val_i,   // far side drive value
  input  wire logic [7:0] ext_en_i,    // far side drive enable
  output logic      [7:0] level_o      // resolved pin level
);
  logic wander_q = 1'b0;  // an undriven line never holds a clean level
  // ==========================================================
  // level resolution
  always_ff @(posedge core_clk_i) begin
    wander_q <= !wander_q;
  end
  // design wins where it drives, then the far side, else noise
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i) | (~pin_oe_i & ~ext_en_i & {8{wander_q}});
endmodule // lsgp_pin_model

// [testbench/lsgp_ports_properties.sv]
// concurrent checks on the apb answers and pin drivers of the shared gpio ports
`timescale 1ns/100ps
module lsgp_ports_properties (
  input wire logic        core_clk_i,              // system clock
  input wire logic        reset_i,                 // synchronous reset
  input wire logic        psel_i,                  // apb select
  input wire logic        penable_i,               // apb access phase
  input wire logic        pwrite_i,                // apb direction
  input wire logic [11:0] paddr_i,                 // apb address
  input wire logic [31:0] prdata_o,                // apb read data
  input wire logic        pready_o,                // apb ready
  input wire logic        pslverr_o,               // apb error
  input wire logic        standby_i,               // standby request
  input wire logic [7:0]  pe_pin_i,                // port e pin levels
  input wire logic [7:0]  pc_pin_oe_o,             // port c driver enables
  input wire logic [7:0]  pe_pin_o,                // port e drive values
  input wire logic [7:0]  pe_pin_oe_o,             // port e driver enables
  input wire logic        timer1_output_a_i,       // timer output to pe6
  input wire logic        timer1_output_a_en_i,    // its enable
  input wire logic        timer1_output_b_i,       // timer output to pe5
  input wire logic        timer1_output_b_en_i,    // its enable
  input wire logic        timer1_external_clock_o  // pe7 to timer
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic acc;  // access phase of a transfer
  assign acc = psel_i && penable_i;
  // pins not floated: standby low long enough to pass the synchroniser
  sequence quiet_s;
    (!standby_i && !reset_i) [*4];
  endsequence
  // ==========================================================
  // assertions
  chk_ready_in_access: assert property (pready_o |-> acc) else $error("ready outside access");
  chk_one_wait_state: assert property (acc && !pready_o |=> pready_o) else $error("ready late");
  chk_err_in_access: assert property (pslverr_o |-> acc) else $error("error outside access");
  chk_err_unmapped: assert property (acc && pready_o && paddr_i > 12'h02C |-> pslverr_o)
    else $error("unmapped not refused");
  chk_ok_mapped: assert property (acc && paddr_i <= 12'h02C && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("mapped refused");
  chk_read_upper_zero: assert property (acc && !pwrite_i |=> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_rdata_holds: assert property (!(acc && !pwrite_i) |=> $stable(prdata_o)) else $error("read data moved");
  chk_reset_inputs: assert property ($fell(reset_i) |-> pc_pin_oe_o == 8'h00) else $error("driver on after reset");
  chk_timer_a_owns: assert property (quiet_s ##0 timer1_output_a_en_i |-> pe_pin_oe_o[6] &&
    pe_pin_o[6] == timer1_output_a_i) else $error("pe6 not timer output");
  chk_timer_b_owns: assert property (quiet_s ##0 timer1_output_b_en_i |-> pe_pin_oe_o[5] &&
    pe_pin_o[5] == timer1_output_b_i) else $error("pe5 not timer output");
  chk_ext_clock_pin: assert property (quiet_s |-> timer1_external_clock_o == $past(pe_pin_i[7], 2))
    else $error("pe7 clock input wrong");
endmodule // lsgp_ports_properties

bind lsgp_ports lsgp_ports_properties lsgp_ports_properties_i (.core_clk_i, .reset_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .standby_i, .pe_pin_i, .pc_pin_oe_o, .pe_pin_o,
  .pe_pin_oe_o, .timer1_output_a_i, .timer1_output_a_en_i, .timer1_output_b_i, .timer1_output_b_en_i,
  .timer1_external_clock_o);

// [testbench/lsgp_ports_tb.sv]
// self-checking bench for the shared lcd gpio ports
`timescale 1ns/100ps
module lsgp_ports_tb
  import lsgp_pkg::*;
;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d, r; lsgp_byte_t coe, co, eoe, eo;} lsgp_row_s;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, stby, ta, ta_en, tb_o, tb_en, ext_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  lsgp_byte_t  pc_lvl, pe_lvl, pc_o, pc_oe, pe_o, pe_oe, pc_seg, pe_seg, ext_val, ext_en;
  int          fail_count = 0;
  int          total_checks = 0;
  // one transfer each: write/read, address, data, read, pc oe, pc out, pe oe, pe out
  localparam lsgp_row_s ROWS [16] = '{
    '{1, 12'h000, 8'hC3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, '{0, 12'h000, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00},
    '{1, 12'h004, 8'h0F, 8'h00, 8'h0F, 8'h03, 8'h00, 8'h00}, '{0, 12'h000, 8'h00, 8'h53, 8'h0F, 8'h03, 8'h00, 8'h00},
    '{1, 12'h000, 8'h3C, 8'h00, 8'h0F, 8'h0C, 8'h00, 8'h00}, '{1, 12'h028, 8'h01, 8'h00, 8'h0F, 8'h0C, 8'h00, 8'h00},
    '{0, 12'h000, 8'h00, 8'h3C, 8'h0F, 8'h0C, 8'h00, 8'h00}, '{1, 12'h028, 8'h00, 8'h00, 8'h0F, 8'h0C, 8'h00, 8'h00},
    '{1, 12'h00C, 8'hFF, 8'h00, 8'h0F, 8'h0C, 8'hFF, 8'h00}, '{1, 12'h008, 8'hA5, 8'h00, 8'h0F, 8'h0C, 8'hFF, 8'hA5},
    '{0, 12'h030, 8'h00, 8'h00, 8'h0F, 8'h0C, 8'hFF, 8'hA5}, '{1, 12'h004, 8'h0E, 8'h00, 8'h0E, 8'h0C, 8'hFF, 8'hA5},
    '{1, 12'h014, 8'h04, 8'h00, 8'h0E, 8'h0C, 8'hFF, 8'hA5}, '{1, 12'h010, 8'h01, 8'h00, 8'h0F, 8'h0D, 8'hFF, 8'hA5},
    '{1, 12'h018, 8'h02, 8'h00, 8'h8F, 8'h8D, 8'hFF, 8'hA5}, '{1, 12'h01C, 8'h80, 8'h00, 8'h8F, 8'h8D, 8'hFF, 8'hA7}};
  // ==========================================================
  // design and far side
  lsgp_ports lsgp_ports_i (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .standby_i(stby), .pc_pin_i(pc_lvl), .pc_pin_o(pc_o), .pc_pin_oe_o(pc_oe), .pe_pin_i(pe_lvl),
    .pe_pin_o(pe_o), .pe_pin_oe_o(pe_oe), .pc_seg_i(pc_seg), .pe_seg_i(pe_seg), .timer1_output_a_i(ta),
    .timer1_output_a_en_i(ta_en), .timer1_output_b_i(tb_o), .timer1_output_b_en_i(tb_en),
    .timer1_external_clock_o(ext_clk));
  lsgp_pin_model lsgp_pin_model_i (.core_clk_i(clk), .pin_o_i(pc_o), .pin_oe_i(pc_oe), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .level_o(pc_lvl));
  lsgp_pin_model lsgp_pin_model_e_i (.core_clk_i(clk), .pin_o_i(pe_o), .pin_oe_i(pe_oe), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .level_o(pe_lvl));
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // apb transfer; read data taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0; stby = 1'b0;
    ta = 1'b1; ta_en = 1'b0; tb_o = 1'b0; tb_en = 1'b0; pc_seg = 8'h99; pe_seg = 8'h66;
    ext_val = 8'h5A; ext_en = 8'hFF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      check(pc_oe, ROWS[i].coe);
      check(pc_o & pc_oe, ROWS[i].co);
      check(pe_oe, ROWS[i].eoe);
      check(pe_o & pe_oe, ROWS[i].eo);
      if (!ROWS[i].wr) check(rd, ROWS[i].r);
    end
    // timer outputs take pe6 and pe5 over the latch
    ta_en <= 1'b1; tb_en <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0);
    check(rd[6:5], 2'b10);
    check({pe_oe[6:5], pe_o[6:5]}, 4'hE);
    apb(1'b1, 12'h028, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'hA5);
    apb(1'b1, 12'h028, 32'h0);
    // standby with float set, then with float clear
    apb(1'b1, 12'h024, 32'h1);
    stby <= 1'b1;
    repeat (4) @(posedge clk);
    check({pc_oe, pe_oe}, 16'h0000);
    check(ext_clk, 1'b0);
    apb(1'b0, 12'h02C, 32'h0);
    check(rd, 32'h1);
    stby <= 1'b0;
    apb(1'b1, 12'h024, 32'h0);
    stby <= 1'b1;
    repeat (4) @(posedge clk);
    check({pc_oe, pe_oe}, 16'h8FFF);
    stby <= 1'b0; ta_en <= 1'b0; tb_en <= 1'b0;
    // reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({pc_oe, pe_oe}, 16'h0000);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    finish_test();
  end
endmodule // lsgp_ports_tb
